// ==== hw/dstc_checker.sv ====
// deserializer self-test checker with axi4-lite status and control
//
// Design decisions made here: the AXI4-Lite register port and the address map.
module dstc_checker #(
   parameter int unsigned LOCK_N = dstc_pkg::LOCK_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // self-test pins
   input wire logic test_mode,
   input wire logic align_pattern_select,
   input wire logic force_toggle_pattern,
   input wire logic [dstc_pkg::WORD_W-1:0] rx_word,
   output logic word_skip,
   output logic match,
   output logic aligned,
   output logic error,
   output logic frame,
   // axi4-lite write
   input wire logic [dstc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [dstc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int unsigned LCNT_W = $clog2(LOCK_N + 1);
   localparam logic [LCNT_W-1:0] LOCK_LOAD = LCNT_W'(LOCK_N - 1);
   localparam logic [1:0] RUN_LAST = 2'(dstc_pkg::MATCH_RUN - 1);
   dstc_pkg::dstc_skip_t skip_st_ff, nxt_skip_st;
   dstc_pkg::dstc_psel_t psel_ff;
   dstc_pkg::dstc_status_t status;
   logic [LCNT_W-1:0] lock_cnt_ff, nxt_lock_cnt;
   logic [1:0] run_cnt_ff, hold_ff;
   logic [11:0] lfsr_ff, lfsr_step, local_word;
   logic skip_ff, match_ff, aligned_ff, error_ff, frame_ff;
   logic test_rst_b, force_alt, enter_aligned, enter_prbs;
   logic [31:0] ctrl_ff;
   logic err_clr_ff;
   logic [dstc_pkg::CNT_W-1:0] frame_cnt_ff, skip_cnt_ff;
   logic awready_ff, wready_ff, bvalid_ff, aw_got_ff, w_got_ff;
   logic arready_ff, rvalid_ff, wr_fire;
   logic [1:0] bresp_ff, rresp_ff, rd_resp;
   logic [dstc_pkg::ADDR_W-1:0] awaddr_ff;
   logic [31:0] wdata_ff, rdata_ff, rd_data;
   logic [3:0] wstrb_ff;
   // test low acts as an asynchronous clear of the skip generator and the error latch
   assign test_rst_b = rst_b & test_mode;

   assign force_alt = force_toggle_pattern | ctrl_ff[dstc_pkg::CTRL_FORCE_BIT];
   assign enter_aligned = align_pattern_select & ~aligned_ff & match_ff
      & (run_cnt_ff == RUN_LAST);
   assign enter_prbs = align_pattern_select & (psel_ff == dstc_pkg::DSTC_PS_SYNC)
      & aligned_ff & ~match_ff;

   assign lfsr_step = {lfsr_ff[10:0], lfsr_ff[dstc_pkg::TAP_A] ^ lfsr_ff[dstc_pkg::TAP_B]
      ^ lfsr_ff[dstc_pkg::TAP_C] ^ lfsr_ff[dstc_pkg::TAP_D]};

   // local pattern generator
   always_comb begin
      if (psel_ff == dstc_pkg::DSTC_PS_SYNC) begin
         local_word = dstc_pkg::SYNC_WORD;
      end else if (force_alt || hold_ff != 2'h0) begin
         local_word = dstc_pkg::ALT_WORD;
      end else begin
         local_word = lfsr_ff;
      end
   end
   // skip edge generator, only fires when test is high
   always_comb begin
      nxt_skip_st = skip_st_ff;
      nxt_lock_cnt = lock_cnt_ff;
      case (skip_st_ff)
         dstc_pkg::DSTC_SK_IDLE: begin
            if (!aligned_ff && !match_ff) begin
               nxt_skip_st = dstc_pkg::DSTC_SK_FIRE;
            end
         end
         dstc_pkg::DSTC_SK_FIRE: begin
            nxt_skip_st = dstc_pkg::DSTC_SK_LOCK;
            nxt_lock_cnt = LOCK_LOAD;
         end
         dstc_pkg::DSTC_SK_LOCK: begin
            if (lock_cnt_ff == '0) begin
               nxt_skip_st = dstc_pkg::DSTC_SK_IDLE;
            end else begin
               nxt_lock_cnt = lock_cnt_ff - LCNT_W'(1);
            end
         end
         default: begin
            nxt_skip_st = dstc_pkg::DSTC_SK_IDLE;
         end
      endcase
   end
   always_ff @(posedge sys_clk or negedge test_rst_b) begin
      if (!test_rst_b) begin
         skip_st_ff <= dstc_pkg::DSTC_SK_IDLE;
         lock_cnt_ff <= '0;
         skip_ff <= 1'b0;
      end else if (!align_pattern_select) begin
         skip_st_ff <= dstc_pkg::DSTC_SK_IDLE;
         lock_cnt_ff <= '0;
         skip_ff <= 1'b0;
      end else begin
         skip_st_ff <= nxt_skip_st;
         lock_cnt_ff <= nxt_lock_cnt;
         skip_ff <= (nxt_skip_st == dstc_pkg::DSTC_SK_FIRE);
      end
   end

   // registered comparator and frame detect
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         match_ff <= 1'b0;
         frame_ff <= 1'b0;
      end else begin
         match_ff <= (local_word == rx_word);
         frame_ff <= (psel_ff == dstc_pkg::DSTC_PS_PRBS) && (hold_ff == 2'h0)
            && !force_alt && (lfsr_ff == dstc_pkg::PRBS_SEED);
      end
   end
   // aligned state machine
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         aligned_ff <= 1'b0;
         run_cnt_ff <= 2'h0;
      end else if (!align_pattern_select) begin
         aligned_ff <= 1'b0;
         run_cnt_ff <= 2'h0;
      end else if (!aligned_ff) begin
         if (enter_aligned) begin
            aligned_ff <= 1'b1;
         end else if (match_ff) begin
            run_cnt_ff <= run_cnt_ff + 2'h1;
         end else begin
            run_cnt_ff <= 2'h0;
         end
      end
   end
   // pattern selector; the mismatch is seen on the first alternating word,
   // two more follow, so the seed is held back one cycle before stepping
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         psel_ff <= dstc_pkg::DSTC_PS_SYNC;
         hold_ff <= 2'h0;
         lfsr_ff <= dstc_pkg::PRBS_SEED;
      end else if (!align_pattern_select) begin
         psel_ff <= dstc_pkg::DSTC_PS_SYNC;
         hold_ff <= 2'h0;
         lfsr_ff <= dstc_pkg::PRBS_SEED;
      end else begin
         case (psel_ff)
            dstc_pkg::DSTC_PS_SYNC: begin
               if (enter_prbs) begin
                  psel_ff <= dstc_pkg::DSTC_PS_PRBS;
                  hold_ff <= dstc_pkg::PRBS_HOLD;
                  lfsr_ff <= dstc_pkg::PRBS_SEED;
               end
            end
            dstc_pkg::DSTC_PS_PRBS: begin
               if (hold_ff != 2'h0) begin
                  hold_ff <= hold_ff - 2'h1;
               end else begin
                  lfsr_ff <= lfsr_step;
               end
            end
            default: begin
               psel_ff <= dstc_pkg::DSTC_PS_SYNC;
            end
         endcase
      end
   end
   // error latch: entry clears outrank a same-cycle mismatch on purpose; the
   // hold cycle still shows the last sync-mode compare; software clear loses
   always_ff @(posedge sys_clk or negedge test_rst_b) begin
      if (!test_rst_b) begin
         error_ff <= 1'b0;
      end else if (enter_aligned || enter_prbs || hold_ff != 2'h0) begin
         error_ff <= 1'b0;
      end else if (!match_ff) begin
         error_ff <= 1'b1;
      end else if (err_clr_ff) begin
         error_ff <= 1'b0;
      end
   end
   // event counters for software
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_cnt_ff <= '0;
         skip_cnt_ff <= '0;
      end else begin
         if (frame_ff) begin
            frame_cnt_ff <= frame_cnt_ff + dstc_pkg::CNT_W'(1);
         end
         if (skip_ff) begin
            skip_cnt_ff <= skip_cnt_ff + dstc_pkg::CNT_W'(1);
         end
      end
   end
   // axi write channel; address and data may arrive in either order
   assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= dstc_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awready_ff) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
            awready_ff <= 1'b0;
         end
         if (s_axi_wvalid && wready_ff) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
            wready_ff <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (awaddr_ff[7:2] <= dstc_pkg::ADDR_SKIPS[7:2])
               ? dstc_pkg::RESP_OKAY : dstc_pkg::RESP_SLVERR;
         end
         if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
         end
      end
   end
   // control register; error clear is a one-cycle write pulse
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff <= dstc_pkg::CTRL_RESET;
         err_clr_ff <= 1'b0;
      end else begin
         err_clr_ff <= 1'b0;
         if (wr_fire && awaddr_ff[7:2] == dstc_pkg::ADDR_CTRL[7:2] && wstrb_ff[0]) begin
            ctrl_ff[dstc_pkg::CTRL_FORCE_BIT] <= wdata_ff[dstc_pkg::CTRL_FORCE_BIT];
            err_clr_ff <= wdata_ff[dstc_pkg::CTRL_ERRCLR_BIT];
         end
      end
   end
   // read decode
   always_comb begin
      status.test = test_mode;
      status.force_alt = force_alt;
      status.hold = (hold_ff != 2'h0);
      status.prbs = (psel_ff == dstc_pkg::DSTC_PS_PRBS);
      status.error = error_ff;
      status.aligned = aligned_ff;
      status.match = match_ff;
      rd_resp = dstc_pkg::RESP_OKAY;
      case (s_axi_araddr[7:2])
         dstc_pkg::ADDR_CTRL[7:2]: rd_data = ctrl_ff;
         dstc_pkg::ADDR_STATUS[7:2]: rd_data = {25'h0, status};
         dstc_pkg::ADDR_FRAMES[7:2]: rd_data = {16'h0, frame_cnt_ff};
         dstc_pkg::ADDR_SKIPS[7:2]: rd_data = {16'h0, skip_cnt_ff};
         default: begin
            rd_data = 32'h0000_0000;
            rd_resp = dstc_pkg::RESP_SLVERR;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= dstc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_data;
         rresp_ff <= rd_resp;
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
      end
   end
   assign word_skip = skip_ff;
   assign match = match_ff;
   assign aligned = aligned_ff;
   assign error = error_ff;
   assign frame = frame_ff;
   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
endmodule

// ==== hw/dstc_pkg.sv ====
// shared constants and types for the deserializer self-test checker
package dstc_pkg;
   // pattern words, leftmost bit first on the line
   localparam int unsigned WORD_W = 12;
   localparam logic [11:0] SYNC_WORD = 12'h956;
   localparam logic [11:0] ALT_WORD = 12'hAAA;
   localparam logic [11:0] PRBS_SEED = 12'h2AA;
   // fibonacci tap positions, x^12 + x^6 + x^4 + x + 1
   localparam int unsigned TAP_A = 11;
   localparam int unsigned TAP_B = 5;
   localparam int unsigned TAP_C = 3;
   localparam int unsigned TAP_D = 0;
   // timing counts in sys_clk cycles
   localparam int unsigned LOCK_CYCLES = 4;
   localparam int unsigned MATCH_RUN = 3;
   localparam logic [1:0] PRBS_HOLD = 2'h1;
   // register map
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_FRAMES = 8'h08;
   localparam logic [7:0] ADDR_SKIPS = 8'h0C;
   localparam int unsigned CTRL_FORCE_BIT = 0;
   localparam int unsigned CTRL_ERRCLR_BIT = 1;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam int unsigned CNT_W = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      DSTC_SK_IDLE = 2'h0,
      DSTC_SK_FIRE = 2'h1,
      DSTC_SK_LOCK = 2'h3
   } dstc_skip_t;

   typedef enum logic {
      DSTC_PS_SYNC = 1'h0,
      DSTC_PS_PRBS = 1'h1
   } dstc_psel_t;

   typedef struct packed {
      logic test;
      logic force_alt;
      logic hold;
      logic prbs;
      logic error;
      logic aligned;
      logic match;
   } dstc_status_t;
endpackage

// ==== testbench/dstc_checker_sva.sv ====
// assertions on the self-test pins of the checker
module dstc_checker_sva #(
   parameter int unsigned LOCK_N = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // self-test pins
   input wire logic test_mode,
   input wire logic align_pattern_select,
   input wire logic word_skip,
   input wire logic match,
   input wire logic aligned,
   input wire logic error,
   input wire logic frame
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] gap_ff;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // saturates so a first skip after reset is never judged too early
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_ff <= 4'hF;
      end else if (word_skip) begin
         gap_ff <= 4'h0;
      end else if (gap_ff != 4'hF) begin
         gap_ff <= gap_ff + 4'h1;
      end
   end
   test_off_a: assert property (!test_mode |-> !word_skip && !error)
      else $error("skip or error with test low");
   aps_zero_a: assert property (!align_pattern_select |=> !word_skip && !aligned)
      else $error("select low did not clear");
   skip_cause_a: assert property (word_skip |-> !$past(match)
      && !$past(aligned) && $past(align_pattern_select))
      else $error("skip without cause");
   skip_gap_a: assert property (word_skip |-> gap_ff > LOCK_N)
      else $error("skip inside lockout");
   align_run_a: assert property ((match && align_pattern_select)[*3] |=> aligned)
      else $error("aligned late");
   align_cause_a: assert property ($rose(aligned) |-> $past(match, 1)
      && $past(match, 2) && $past(match, 3))
      else $error("aligned early");
   align_hold_a: assert property (aligned && align_pattern_select |=> aligned)
      else $error("aligned dropped");
   err_set_a: assert property (test_mode && !match && !aligned |=> error || !test_mode)
      else $error("mismatch not latched");
   err_clear_a: assert property ($rose(aligned) |-> !error)
      else $error("error kept on aligned entry");
   frame_pulse_a: assert property (frame |=> !frame)
      else $error("frame longer than one cycle");
endmodule
bind dstc_checker dstc_checker_sva #(.LOCK_N(LOCK_N)) i_dstc_checker_sva (.sys_clk(sys_clk),
   .rst_b(rst_b), .test_mode(test_mode), .align_pattern_select(align_pattern_select),
   .word_skip(word_skip), .match(match), .aligned(aligned), .error(error), .frame(frame));

// ==== testbench/dstc_serializer_model.sv ====
// serializer pattern source plus word rotation in front of the checker
module dstc_serializer_model #(
   parameter int unsigned ROT0 = 3
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // control
   input wire logic align_pattern_select,
   input wire logic word_skip,
   input wire logic flip_bit,
   // rotated word
   output logic [11:0] rx_word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] tx_ff;
   logic [2:0] step_ff;
   logic [3:0] rot_ff;
   logic [23:0] dbl;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b || !align_pattern_select) begin
         tx_ff <= dstc_pkg::SYNC_WORD;
         step_ff <= 3'h0;
      end else begin
         if (step_ff < 3'h3) begin
            tx_ff <= dstc_pkg::ALT_WORD;
         end else if (step_ff == 3'h3) begin
            tx_ff <= dstc_pkg::PRBS_SEED;
         end else begin
            tx_ff <= {tx_ff[10:0], tx_ff[11] ^ tx_ff[5] ^ tx_ff[3] ^ tx_ff[0]};
         end
         if (step_ff != 3'h4) begin
            step_ff <= step_ff + 3'h1;
         end
      end
   end
   // only the checker's word_skip pulses rotate, one bit each, wrapping from 11 to 0
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rot_ff <= 4'(ROT0);
      end else if (word_skip) begin
         rot_ff <= (rot_ff == 4'hB) ? 4'h0 : rot_ff + 4'h1;
      end
   end
   assign dbl = {tx_ff, tx_ff};
   assign rx_word = dbl[5'h17 - {1'b0, rot_ff} -: 12] ^ {11'h000, flip_bit};
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench for the deserializer self-test checker
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned ROT0 = 3;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic test_mode = 1'b0;
   logic align_pattern_select = 1'b0;
   logic force_toggle_pattern = 1'b0;
   logic flip_bit = 1'b0;
   logic [11:0] rx_word;
   logic word_skip, match, aligned, error, frame;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   int n;
   dstc_checker i_dstc_checker (.sys_clk, .rst_b, .test_mode, .align_pattern_select,
      .force_toggle_pattern, .rx_word, .word_skip, .match, .aligned, .error, .frame,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   dstc_serializer_model #(.ROT0(ROT0)) i_dstc_serializer_model (.sys_clk, .rst_b,
      .align_pattern_select(aligned), .word_skip, .flip_bit, .rx_word);
   always #5 sys_clk = ~sys_clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one write or one read; waits on the answer, the watchdog bounds it
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_bready <= wr;
      s_axi_arvalid <= !wr;
      s_axi_rready <= !wr;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic t_idle;
      bus(1'b0, 8'h10, 32'h0);
      chk(r, dstc_pkg::RESP_SLVERR);
      chk(d, 32'h0);
      bus(1'b1, dstc_pkg::ADDR_CTRL, 32'h3);
      chk(r, dstc_pkg::RESP_OKAY);
      bus(1'b0, dstc_pkg::ADDR_CTRL, 32'h0);
      chk(r, dstc_pkg::RESP_OKAY);
      chk(d, 32'h1);
      bus(1'b1, dstc_pkg::ADDR_CTRL, 32'h0);
      align_pattern_select <= 1'b1;
      repeat (40) @(posedge sys_clk);
      bus(1'b0, dstc_pkg::ADDR_SKIPS, 32'h0);
      chk(d, 32'h0);
      chk(error, 1'b0);
   endtask
   task automatic t_align;
      test_mode <= 1'b1;
      for (n = 0; n < 300 && aligned !== 1'b1; n++) @(posedge sys_clk);
      chk(aligned, 1'b1);
      chk(error, 1'b0);
   endtask
   task automatic t_prbs;
      for (n = 0; n < 50 && frame !== 1'b1; n++) @(posedge sys_clk);
      chk(frame, 1'b1);
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (frame !== 1'b1 && n < 5000);
      chk(n, 4095);
      chk(error, 1'b0);
      bus(1'b0, dstc_pkg::ADDR_STATUS, 32'h0);
      chk(d, 32'h4B);
      bus(1'b0, dstc_pkg::ADDR_SKIPS, 32'h0);
      chk(d, 32'(12 - ROT0));
      bus(1'b0, dstc_pkg::ADDR_FRAMES, 32'h0);
      chk(d, 32'h2);
   endtask
   task automatic t_error;
      @(posedge sys_clk);
      flip_bit <= 1'b1;
      @(posedge sys_clk);
      flip_bit <= 1'b0;
      @(posedge sys_clk);
      chk(match, 1'b0);
      @(posedge sys_clk);
      chk(match, 1'b1);
      repeat (20) @(posedge sys_clk);
      chk(error, 1'b1);
      bus(1'b1, dstc_pkg::ADDR_CTRL, 32'h2);
      repeat (3) @(posedge sys_clk);
      chk(error, 1'b0);
   endtask
   task automatic t_resync;
      force_toggle_pattern <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk(error, 1'b1);
      align_pattern_select <= 1'b0;
      force_toggle_pattern <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk(aligned, 1'b0);
      repeat (6) @(posedge sys_clk);
      chk(match, 1'b1);
      align_pattern_select <= 1'b1;
      for (n = 0; n < 20 && aligned !== 1'b1; n++) @(posedge sys_clk);
      chk(aligned, 1'b1);
      bus(1'b0, dstc_pkg::ADDR_SKIPS, 32'h0);
      chk(d, 32'(12 - ROT0));
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_idle();
      t_align();
      t_prbs();
      t_error();
      t_resync();
      end_of_test();
   end
   // one sequence period plus setup stay well under this ceiling
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         end_of_test();
      end
   end
endmodule
